// file: verilog/fpc_host.sv
// Host controller that issues protection and unlock-skip command sequences.
// Assumes the flash is already in the mode each operation needs entering.
//
// Behaviour
// - Lock mode: program entry then set, later exit entry and exit to read.
// - Volatile mode: program entry then sector write of set or clear data.
// - Unlock-skip: one write dispatches; reset entry then zero returns to read.
// - Timeout hangs with ready set until software reset is written.
// - Only lock mode follows program entry plus data with exit entry plus exit.
`timescale 1ns/100ps
module fpc_host
	import fpc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// User command
	input wire logic opValid,
	input wire fpc_pkg::fpc_op_e opCode,
	input wire logic [22:0] opAddr,
	input wire logic [7:0] opData,
	input wire logic eraseAllowed,
	output logic opReady,
	output logic opDone,
	output logic opHung,
	output logic [7:0] statusWord,
	// Flash pins
	output logic [22:0] flashAddr,
	output logic [7:0] dqOut,
	output logic dqOe,
	input wire logic [7:0] dqIn,
	output logic weN,
	output logic oeN,
	output logic ceN
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_ISSUE = 6'b000010,
		ST_WAIT = 6'b000100,
		ST_POLL = 6'b001000,
		ST_POLLW = 6'b010000,
		ST_DONE = 6'b100000
	} fpc_state_e;

	fpc_state_e state_reg, state_next;
	fpc_op_e op_reg, op_next;
	logic [22:0] a_reg, a_next;
	logic [7:0] d_reg, d_next;
	logic [2:0] step_reg, step_next;
	logic [2:0] nsteps_reg, nsteps_next;
	logic poll_reg, poll_next;
	logic opReady_next, opDone_next, opHung_next;
	logic [7:0] statusWord_next;
	logic cycStart;
	logic cycRead;
	logic [22:0] cycAddr;
	logic [7:0] cycData;
	logic cycDone;
	logic [7:0] cycRd;

	// ****************************************
	// Sequence tables
	// ****************************************
	// Number of write cycles for each operation
	function automatic logic [2:0] seqLen(input fpc_op_e op);
		case (op)
			OP_GUARD_LOCK: seqLen = 3'd4;
			OP_VGUARD_SET, OP_VGUARD_CLR: seqLen = 3'd2;
			OP_GUARD_PROG: seqLen = 3'd2;
			OP_GUARD_ERASE: seqLen = 3'd2;
			OP_SKIP_CMD: seqLen = 3'd1;
			OP_SKIP_RESET: seqLen = 3'd2;
			default: seqLen = 3'd1;
		endcase
	endfunction : seqLen

	// Address and data of one step; wr[30:8] address, wr[7:0] data
	function automatic logic [30:0] seqCycle(input fpc_op_e op, input logic [2:0] s,
		input logic [22:0] a, input logic [7:0] d);
		seqCycle = {ADDR_ZERO, CMD_RESET};
		case (op)
			// Lock: entry, set, then exit entry, exit to read
			OP_GUARD_LOCK:
				case (s)
					3'd0: seqCycle = {ADDR_ZERO, CMD_PROG_ENTRY};
					3'd1: seqCycle = {ADDR_ZERO, CMD_GUARD_SET};
					3'd2: seqCycle = {ADDR_ZERO, CMD_EXIT_ENTRY};
					default: seqCycle = {ADDR_ZERO, CMD_EXIT};
				endcase
			// Volatile set always writes the only valid set code
			OP_VGUARD_SET: seqCycle = (s == 3'd0) ? {ADDR_ZERO, CMD_PROG_ENTRY}
				: {a, CMD_GUARD_SET};
			OP_VGUARD_CLR: seqCycle = (s == 3'd0) ? {ADDR_ZERO, CMD_PROG_ENTRY}
				: {a, CMD_VGUARD_CLR};
			OP_GUARD_PROG: seqCycle = (s == 3'd0) ? {ADDR_ZERO, CMD_PROG_ENTRY}
				: {a, CMD_GUARD_SET};
			OP_GUARD_ERASE: seqCycle = (s == 3'd0) ? {ADDR_ZERO, CMD_ERASE_ALL_ENTER}
				: {ADDR_ZERO, CMD_ERASE_ALL_START};
			OP_SKIP_CMD: seqCycle = {a, d};
			OP_SKIP_RESET: seqCycle = (s == 3'd0) ? {ADDR_ZERO, CMD_SKIP_RESET}
				: {ADDR_ZERO, CMD_SKIP_RESET2};
			default: seqCycle = {ADDR_ZERO, CMD_RESET};
		endcase
	endfunction : seqCycle

	assign {cycAddr, cycData} = (state_reg == ST_POLL) ? {ADDR_STATUS, CMD_STATUS_RD}
		: seqCycle(op_reg, step_reg, a_reg, d_reg);
	// Read launch is a one-cycle pulse so the engine is not restarted once idle
	assign cycRead = (state_reg == ST_POLLW) && (step_reg == 3'd2);
	assign cycStart = (state_reg == ST_ISSUE) || (state_reg == ST_POLL);

	fpc_bus_cycle u_cycle (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.start(cycStart || cycRead),
		.isRead(cycRead),
		.addrIn(cycRead ? ADDR_ZERO : cycAddr),
		.dataIn(cycData),
		.done(cycDone),
		.rdData(cycRd),
		.flashAddr(flashAddr),
		.dqOut(dqOut),
		.dqOe(dqOe),
		.dqIn(dqIn),
		.weN(weN),
		.oeN(oeN),
		.ceN(ceN)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	// Issue steps, then poll status for timed operations
	always_comb
	begin
		state_next = state_reg;
		op_next = op_reg;
		a_next = a_reg;
		d_next = d_reg;
		step_next = step_reg;
		nsteps_next = nsteps_reg;
		poll_next = poll_reg;
		opReady_next = 1'b0;
		opDone_next = 1'b0;
		opHung_next = opHung;
		statusWord_next = statusWord;
		case (state_reg)
			ST_IDLE:
			begin
				opReady_next = 1'b1;
				if (opValid && opReady)
				begin
					opReady_next = 1'b0;
					op_next = opCode;
					a_next = opAddr;
					d_next = opData;
					step_next = 3'd0;
					nsteps_next = seqLen(opCode);
					poll_next = (opCode == OP_GUARD_PROG) || (opCode == OP_GUARD_ERASE);
					if (opCode == OP_SOFT_RESET)
						opHung_next = 1'b0;
					// Skip erase-all when lock register forbids it
					if (opCode == OP_GUARD_ERASE && !eraseAllowed)
						state_next = ST_DONE;
					else
						state_next = ST_ISSUE;
				end
			end
			ST_ISSUE: state_next = ST_WAIT;
			ST_WAIT:
				if (cycDone)
				begin
					if (step_reg + 3'd1 == nsteps_reg)
						state_next = poll_reg ? ST_POLL : ST_DONE;
					else
					begin
						step_next = step_reg + 3'd1;
						state_next = ST_ISSUE;
					end
				end
			ST_POLL:
			begin
				step_next = 3'd0;
				state_next = ST_POLLW;
			end
			ST_POLLW:
				if (step_reg == 3'd2)
					step_next = 3'd1;
				else if (cycDone)
				begin
					if (step_reg == 3'd0)
						step_next = 3'd2;
					else
					begin
						statusWord_next = cycRd;
						// Ready bit: done (device back in guard mode) or hung
						if (cycRd[STATUS_READY_BIT])
						begin
							opHung_next = cycRd[STATUS_TIMEOUT_BIT];
							state_next = ST_DONE;
						end
						else
							state_next = ST_POLL;
					end
				end
			ST_DONE:
			begin
				opDone_next = 1'b1;
				state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			state_reg <= ST_IDLE;
			op_reg <= OP_SOFT_RESET;
			a_reg <= 23'h0;
			d_reg <= 8'h00;
			step_reg <= 3'd0;
			nsteps_reg <= 3'd1;
			poll_reg <= 1'b0;
			opReady <= 1'b0;
			opDone <= 1'b0;
			opHung <= 1'b0;
			statusWord <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			op_reg <= op_next;
			a_reg <= a_next;
			d_reg <= d_next;
			step_reg <= step_next;
			nsteps_reg <= nsteps_next;
			poll_reg <= poll_next;
			opReady <= opReady_next;
			opDone <= opDone_next;
			opHung <= opHung_next;
			statusWord <= statusWord_next;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_done_after_issue: assert property (@(posedge ref_clk) disable iff (!nrst)
		opDone |-> $past(state_reg) == ST_DONE)
		else $error("done without done state");
	a_erase_blocked: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_IDLE && opValid && opReady && opCode == OP_GUARD_ERASE
		&& !eraseAllowed) |=> state_reg == ST_DONE ##1 opDone)
		else $error("erase issued while forbidden");
	a_reset_unhangs: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_IDLE && opValid && opReady && opCode == OP_SOFT_RESET)
		|=> !opHung)
		else $error("hang not cleared by reset");
	a_we_pulse_len: assert property (@(posedge ref_clk) disable iff (!nrst)
		$fell(weN) |-> !weN [*4] ##1 weN)
		else $error("write strobe width wrong");
	a_oe_we_excl: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(weN == 1'b0 && oeN == 1'b0))
		else $error("read and write overlap");
	a_vset_data: assert property (@(posedge ref_clk) disable iff (!nrst)
		(op_reg == OP_VGUARD_SET && step_reg == 3'd1 && state_reg == ST_WAIT && !weN)
		|-> dqOut == CMD_GUARD_SET)
		else $error("volatile set data wrong");
	a_skip_one_write: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_WAIT && op_reg == OP_SKIP_CMD && cycDone) |=> state_reg == ST_DONE)
		else $error("skip command not single write");
	a_poll_after_prog: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_WAIT && poll_reg && cycDone && step_reg + 3'd1 == nsteps_reg)
		|=> state_reg == ST_POLL)
		else $error("no status poll after guard op");
endmodule : fpc_host

// file: verilog/fpc_pkg.sv
// Package for the flash protection command host controller.
// Assumes a parallel NOR flash driven by write cycles on address/data pins.
package fpc_pkg;
	// ****************************************
	// Command codes
	// ****************************************
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_STATUS_RD = 8'h70;
	localparam logic [7:0] CMD_EXIT_ENTRY = 8'h90;
	localparam logic [7:0] CMD_EXIT = 8'h00;
	localparam logic [7:0] CMD_PROG_ENTRY = 8'ha0;
	localparam logic [7:0] CMD_GUARD_SET = 8'h00;
	localparam logic [7:0] CMD_VGUARD_CLR = 8'h01;
	localparam logic [7:0] CMD_ERASE_ALL_ENTER = 8'h80;
	localparam logic [7:0] CMD_ERASE_ALL_START = 8'h30;
	localparam logic [7:0] CMD_SKIP_WBUF = 8'h25;
	localparam logic [7:0] CMD_SKIP_ERASE = 8'h80;
	localparam logic [7:0] CMD_SKIP_RESET = 8'h90;
	localparam logic [7:0] CMD_SKIP_RESET2 = 8'h00;
	localparam logic [22:0] ADDR_STATUS = 23'h000555;
	localparam logic [22:0] ADDR_ZERO = 23'h000000;
	localparam int STATUS_READY_BIT = 7;
	localparam int STATUS_TIMEOUT_BIT = 5;
	localparam int LOCK_ERASE_OK_BIT = 3;
	// ****************************************
	// Bus cycle timing (ref_clk cycles at 100 MHz)
	// ****************************************
	localparam int CLK_NS = 10;
	localparam int WE_LOW_NS = 40;
	localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_ACC_NS = 70;
	localparam int RD_ACC_CYC = (RD_ACC_NS + CLK_NS - 1) / CLK_NS;
	// ****************************************
	// Host operations
	// ****************************************
	typedef enum logic [3:0] {
		OP_GUARD_LOCK = 4'h0,
		OP_VGUARD_SET = 4'h1,
		OP_VGUARD_CLR = 4'h2,
		OP_GUARD_PROG = 4'h3,
		OP_GUARD_ERASE = 4'h4,
		OP_SKIP_CMD = 4'h5,
		OP_SKIP_RESET = 4'h6,
		OP_SOFT_RESET = 4'h7
	} fpc_op_e;
endpackage : fpc_pkg

// file: verilog/fpc_bus_cycle.sv
// Single flash bus cycle engine: one write or one status read.
// Assumes flash pins are external; read data is synchronised here.
`timescale 1ns/100ps
module fpc_bus_cycle
	import fpc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Request
	input wire logic start,
	input wire logic isRead,
	input wire logic [22:0] addrIn,
	input wire logic [7:0] dataIn,
	output logic done,
	output logic [7:0] rdData,
	// Flash pins
	output logic [22:0] flashAddr,
	output logic [7:0] dqOut,
	output logic dqOe,
	input wire logic [7:0] dqIn,
	output logic weN,
	output logic oeN,
	output logic ceN
);
	logic [7:0] dqSync1_reg;
	logic [7:0] dqSync2_reg;
	logic [3:0] cnt_reg, cnt_next;
	logic busy_reg, busy_next;
	logic rd_reg, rd_next;
	logic [22:0] addr_reg, addr_next;
	logic [7:0] wd_reg, wd_next;
	logic [7:0] rdData_next;
	logic done_next;

	// ****************************************
	// Cycle sequencing
	// ****************************************
	// Hold strobe for a fixed count, then sample/release
	always_comb
	begin
		busy_next = busy_reg;
		cnt_next = cnt_reg;
		rd_next = rd_reg;
		addr_next = addr_reg;
		wd_next = wd_reg;
		rdData_next = rdData;
		done_next = 1'b0;
		if (!busy_reg && start)
		begin
			busy_next = 1'b1;
			rd_next = isRead;
			addr_next = addrIn;
			wd_next = dataIn;
			cnt_next = 4'h0;
		end
		else if (busy_reg)
		begin
			cnt_next = cnt_reg + 4'h1;
			// Read waits access time plus two sync stages; write strobe stays low
			// for exactly WE_LOW_CYC cycles, the launch edge counting as the first
			if (rd_reg ? (cnt_reg == 4'(RD_ACC_CYC + 2)) : (cnt_reg == 4'(WE_LOW_CYC - 1)))
			begin
				busy_next = 1'b0;
				done_next = 1'b1;
				if (rd_reg)
					rdData_next = dqSync2_reg;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		dqSync1_reg <= dqIn;
		dqSync2_reg <= dqSync1_reg;
		if (!nrst)
		begin
			busy_reg <= 1'b0;
			cnt_reg <= 4'h0;
			rd_reg <= 1'b0;
			addr_reg <= 23'h0;
			wd_reg <= 8'h00;
			rdData <= 8'h00;
			done <= 1'b0;
			flashAddr <= 23'h0;
			dqOut <= 8'h00;
			dqOe <= 1'b0;
			weN <= 1'b1;
			oeN <= 1'b1;
			ceN <= 1'b1;
		end
		else
		begin
			busy_reg <= busy_next;
			cnt_reg <= cnt_next;
			rd_reg <= rd_next;
			addr_reg <= addr_next;
			wd_reg <= wd_next;
			rdData <= rdData_next;
			done <= done_next;
			flashAddr <= addr_next;
			dqOut <= wd_next;
			dqOe <= busy_next && !rd_next;
			weN <= !(busy_next && !rd_next);
			oeN <= !(busy_next && rd_next);
			ceN <= !busy_next;
		end
	end
endmodule : fpc_bus_cycle

// file: tb/fpc_flash_model.sv
// Flash model: protection modes and unlock-skip dispatch.
// Assumes the host holds address and data while weN is low.
`timescale 1ns/100ps
module fpc_flash_model
	import fpc_pkg::*;
#(
	parameter int BUSY = 20
)
(
	// Test control
	input wire logic ref_clk,
	input wire logic enter,
	input wire logic [1:0] mode,
	input wire logic eraseOk,
	input wire logic hangNext,
	// Flash pins
	input wire logic [22:0] flashAddr,
	input wire logic [7:0] dqOut,
	input wire logic dqOe,
	input wire logic weN,
	input wire logic oeN,
	input wire logic ceN,
	output logic [7:0] dqIn,
	// Observed state
	output logic [3:0] st,
	output logic lockBit,
	output logic [15:0] gBits,
	output logic [15:0] vBits,
	output logic [7:0] lastCmd,
	output logic [7:0] nWrites
);
	// ****
	// Command state
	// ****
	localparam logic [3:0] S_READ = 4'h0, S_MODE = 4'h1, S_PG1 = 4'h2, S_EXT = 4'h3;
	localparam logic [3:0] S_BER = 4'h4, S_BUSY = 4'h5, S_HANG = 4'h6, S_RST = 4'h7;
	logic weD = 1'b1;
	logic [22:0] a = 23'h000000;
	logic [7:0] d = 8'h00;
	logic [7:0] sr = 8'h80;
	logic [7:0] lastDq = 8'h00;
	logic [15:0] saved;
	logic [15:0] pend;
	int cnt;
	initial
	begin
		st = S_READ;
		lockBit = 1'b0;
		gBits = 16'h0000;
		vBits = 16'h0000;
		lastCmd = 8'h00;
		nWrites = 8'h00;
	end
	// Released bus shows the inverse of the last value, not a stale copy
	assign dqIn = (!oeN && !ceN) ? sr : ~lastDq;
	task automatic start_busy(input logic [15:0] nxt);
		saved = gBits;
		pend = nxt;
		cnt = BUSY;
		sr = 8'h00;
		st = S_BUSY;
	endtask : start_busy
	task automatic take_write();
		nWrites = nWrites + 8'h01;
		if (d == CMD_RESET && st != S_BUSY)
			st = (st == S_HANG) ? S_MODE : S_READ;
		else if (st == S_MODE && mode == 2'd3)
		begin
			lastCmd = d;
			if (d == CMD_SKIP_RESET)
				st = S_RST;
		end
		else if (st == S_MODE && d == CMD_EXIT_ENTRY)
			st = S_EXT;
		else if (st == S_MODE && d == CMD_PROG_ENTRY)
			st = S_PG1;
		else if (st == S_MODE && mode == 2'd0 && d == CMD_ERASE_ALL_ENTER && eraseOk)
			st = S_BER;
		else if (st == S_PG1 && mode == 2'd2 && (d == CMD_GUARD_SET || d == CMD_VGUARD_CLR))
		begin
			vBits[a[18:15]] = (d == CMD_GUARD_SET);
			st = S_MODE;
		end
		else if (st == S_PG1 && d == CMD_GUARD_SET && mode == 2'd1)
		begin
			lockBit = 1'b1;
			st = S_MODE;
		end
		else if (st == S_PG1 && d == CMD_GUARD_SET)
			start_busy(gBits | (16'h0001 << a[18:15]));
		else if (st == S_BER && d == CMD_ERASE_ALL_START)
			start_busy(16'h0000);
		else if ((st == S_EXT || st == S_RST) && d == CMD_EXIT)
			st = S_READ;
	endtask : take_write
	// Timeout keeps old guard bits: a failed operation never weakens them
	task automatic finish_busy();
		gBits = hangNext ? saved : pend;
		sr = hangNext ? 8'ha0 : 8'h80;
		st = hangNext ? S_HANG : S_MODE;
	endtask : finish_busy
	// Writes act once the strobe is back high
	always @(posedge ref_clk)
	begin
		weD <= weN;
		// Data only counts while the host really drives the bus
		if (!weN && !ceN && dqOe)
		begin
			a = flashAddr;
			d = dqOut;
		end
		if (!oeN && !ceN)
			lastDq <= sr;
		if (enter)
			st = S_MODE;
		else if (weN && !weD)
			take_write();
		else if (st == S_BUSY && --cnt == 0)
			finish_busy();
	end
endmodule : fpc_flash_model

// file: tb/fpc_host_test.sv
// Self-checking bench for the protection command host.
// Assumes the flash model stands on the far side of the pins.
`timescale 1ns/100ps
module fpc_host_test;
	import fpc_pkg::*;
	// ****
	// Signals
	// ****
	localparam logic [3:0] S_READ = 4'h0, S_MODE = 4'h1, S_HANG = 4'h6;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic opValid = 1'b0;
	fpc_op_e opCode = OP_SOFT_RESET;
	logic [22:0] opAddr = 23'h000000;
	logic [7:0] opData = 8'h00;
	logic eraseAllowed = 1'b0;
	logic enter = 1'b0;
	logic [1:0] mode = 2'd0;
	logic hangNext = 1'b0;
	logic opReady, opDone, opHung, dqOe, weN, oeN, ceN, lockBit;
	logic [7:0] statusWord, dqOut, dqIn, lastCmd, nWrites, w0;
	logic [22:0] flashAddr;
	logic [3:0] st;
	logic [15:0] gBits, vBits;
	int n_errors = 0;
	int tests_run = 0;
	fpc_host fpc_host_inst (.ref_clk, .nrst, .opValid, .opCode, .opAddr, .opData,
		.eraseAllowed, .opReady, .opDone, .opHung, .statusWord, .flashAddr, .dqOut,
		.dqOe, .dqIn, .weN, .oeN, .ceN);
	fpc_flash_model #(.BUSY(20)) fpc_flash_model_inst (.ref_clk, .enter, .mode,
		.eraseOk(eraseAllowed), .hangNext, .flashAddr, .dqOut, .dqOe, .weN, .oeN, .ceN, .dqIn,
		.st, .lockBit, .gBits, .vBits, .lastCmd, .nWrites);
	always #5 ref_clk = ~ref_clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict();
		if (n_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	// One request, held until opReady, then wait for opDone
	task automatic run_op(input fpc_op_e op, input logic [22:0] a, input logic [7:0] d);
		int n;
		@(negedge ref_clk);
		opValid = 1'b1;
		opCode = op;
		opAddr = a;
		opData = d;
		for (n = 0; opReady !== 1'b1 && n < 100; n++)
			@(negedge ref_clk);
		@(negedge ref_clk);
		opValid = 1'b0;
		for (n = 0; opDone !== 1'b1 && n < 1000; n++)
			@(negedge ref_clk);
		chk(opDone, 1'b1);
		repeat (3) @(negedge ref_clk);
	endtask : run_op
	task automatic set_mode(input logic [1:0] m);
		@(negedge ref_clk);
		mode = m;
		enter = 1'b1;
		@(negedge ref_clk);
		enter = 1'b0;
	endtask : set_mode
	task automatic t_lock();
		set_mode(2'd1);
		w0 = nWrites;
		run_op(OP_GUARD_LOCK, 23'h000000, 8'h00);
		chk(lockBit, 1'b1);
		chk(st, S_READ);
		chk(nWrites - w0, 8'h04);
	endtask : t_lock
	task automatic t_vol();
		set_mode(2'd2);
		run_op(OP_VGUARD_SET, 23'h028000, 8'h00);
		chk(vBits, 16'h0020);
		run_op(OP_VGUARD_CLR, 23'h028000, 8'h00);
		chk(vBits, 16'h0000);
		chk(st, S_MODE);
	endtask : t_vol
	task automatic t_guard();
		set_mode(2'd0);
		run_op(OP_GUARD_PROG, 23'h018000, 8'h00);
		chk(gBits, 16'h0008);
		chk(st, S_MODE);
		chk({opHung, statusWord}, 9'h080);
		w0 = nWrites;
		run_op(OP_GUARD_ERASE, 23'h000000, 8'h00);
		chk(nWrites - w0, 8'h00);
		eraseAllowed = 1'b1;
		run_op(OP_GUARD_ERASE, 23'h000000, 8'h00);
		chk(gBits, 16'h0000);
		chk(st, S_MODE);
	endtask : t_guard
	task automatic t_hang();
		run_op(OP_GUARD_PROG, 23'h020000, 8'h00);
		hangNext = 1'b1;
		run_op(OP_GUARD_PROG, 23'h038000, 8'h00);
		chk({opHung, statusWord}, 9'h1a0);
		chk(gBits, 16'h0010);
		chk(st, S_HANG);
		hangNext = 1'b0;
		run_op(OP_SOFT_RESET, 23'h000000, 8'h00);
		chk(opHung, 1'b0);
		chk(st, S_MODE);
	endtask : t_hang
	task automatic t_skip();
		logic [7:0] codes [3] = '{CMD_SKIP_WBUF, CMD_SKIP_ERASE, CMD_PROG_ENTRY};
		set_mode(2'd3);
		foreach (codes[i])
		begin
			run_op(OP_SKIP_CMD, 23'h000100, codes[i]);
			chk(lastCmd, codes[i]);
		end
		run_op(OP_SKIP_RESET, 23'h000000, 8'h00);
		chk(st, S_READ);
	endtask : t_skip
	// Main sequence
	initial
	begin
		repeat (2) @(negedge ref_clk);
		nrst = 1'b1;
		t_lock();
		t_vol();
		t_guard();
		t_hang();
		t_skip();
		print_verdict();
	end
	// Watchdog, well past the expected run of about 4 us
	initial
	begin
		#200000;
		n_errors++;
		print_verdict();
	end
endmodule : fpc_host_test
